// [verilog/ldac_pkg.sv]
// Package with constants and carrier types for the ladder converter control
package ldac_pkg;
  localparam int unsigned LEVEL_W = 5;
  localparam int unsigned LEVELS = 32;
  localparam logic [4:0] LEVEL_ZERO = 5'h00;
  localparam logic [4:0] LEVEL_ONES = 5'h1f;

  typedef enum logic [1:0] {
    LDAC_TOP_SUPPLY = 2'h0,
    LDAC_TOP_EXTREF = 2'h1,
    LDAC_TOP_FIXED  = 2'h2
  } ldac_top_sel_t;

  typedef enum logic {
    LDAC_BOT_GROUND = 1'h0,
    LDAC_BOT_EXTREF = 1'h1
  } ldac_bot_sel_t;

  // Software-visible control bits
  typedef struct packed {
    logic          conv_enable;
    logic          low_power_source_sel;
    logic          pin_output_enable;
    ldac_top_sel_t positive_source_sel;
    ldac_bot_sel_t negative_source_sel;
    logic [4:0]    level_code;
  } ldac_ctrl_t;

  // Analog switch controls toward the ladder
  typedef struct packed {
    logic          top_connect;
    logic          bot_connect;
    ldac_top_sel_t top_sel;
    ldac_bot_sel_t bot_sel;
    logic [4:0]    tap_sel;
    logic          tap_drive;
    logic          route_cmp;
    logic          route_adc;
    logic          route_pin;
  } ldac_ladder_t;

  localparam ldac_ctrl_t CTRL_RESET = '{
    conv_enable:          1'b0,
    low_power_source_sel: 1'b0,
    pin_output_enable:    1'b0,
    positive_source_sel:  LDAC_TOP_SUPPLY,
    negative_source_sel:  LDAC_BOT_GROUND,
    level_code:           5'h00
  };
endpackage

// [verilog/ldac_pin_mux.sv]
// Output pin digital buffer override for the converter pin
`timescale 1ns/1ns
`default_nettype none
module ldac_pin_mux (
  // Converter routing
  input  wire logic analog_sel,
  // Port logic side
  input  wire logic port_out,
  input  wire logic port_tris,
  input  wire logic pad_in,
  // Pad side
  output logic      pad_out,
  output logic      pad_oe_n,
  output logic      pad_ibuf_en,
  output logic      port_read
);
  always_comb begin
    pad_out     = port_out;
    pad_oe_n    = port_tris;
    pad_ibuf_en = 1'b1;
    port_read   = pad_in;
    if (analog_sel) begin
      pad_out     = 1'b0;
      pad_oe_n    = 1'b1;
      pad_ibuf_en = 1'b0;
      port_read   = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [verilog/ladder_dac_control.sv]
// Control logic of the 32-step resistor-ladder reference converter
//
// Contract
// - Ladder tap drives output only while enabled.
// - Five-bit level code selects one of 32.
// - Output is bottom plus difference times code/32.
// - Top: supply, external or fixed; bottom: ground/external.
// - Low-power bit set drops bottom, clear drops top.
// - Output goes to comparator, converter channel, pin.
// - Pin enable bit routes level onto pin.
// - Pin enable kills digital driver and input buffer.
// - Pin digital read returns zero while routed.
`timescale 1ns/1ns
`default_nettype none
module ladder_dac_control (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic                 clk_en,
  // Software control
  input  wire logic                 ctrl_we,
  input  wire ldac_pkg::ldac_ctrl_t ctrl_wdata,
  output ldac_pkg::ldac_ctrl_t      ctrl_rdata,
  // Ladder switches
  output ldac_pkg::ldac_ladder_t    ladder,
  // Pin port logic, from pad domain
  input  wire logic                 port_out,
  input  wire logic                 port_tris,
  input  wire logic                 pad_in,
  // Pad controls and read
  output logic                      pad_out,
  output logic                      pad_oe_n,
  output logic                      pad_ibuf_en,
  output logic                      port_read
);
  ldac_pkg::ldac_ctrl_t   ctrl_q;
  ldac_pkg::ldac_ctrl_t   ctrl_d;
  ldac_pkg::ldac_ladder_t ladder_q;
  ldac_pkg::ldac_ladder_t ladder_d;
  logic [2:0]             pad_sync_q;
  logic [2:0]             pad_sync_d;
  logic                   pad_in_q;
  logic                   pad_in_d;
  logic                   mux_out;
  logic                   mux_oe_n;
  logic                   mux_ibuf;
  logic                   mux_read;
  logic                   pad_out_q;
  logic                   pad_oe_n_q;
  logic                   pad_ibuf_q;
  logic                   port_read_q;

  // Unused top encoding falls back to the supply rail
  function automatic ldac_pkg::ldac_top_sel_t legal_top(input ldac_pkg::ldac_top_sel_t s);
    case (s)
      ldac_pkg::LDAC_TOP_SUPPLY,
      ldac_pkg::LDAC_TOP_EXTREF,
      ldac_pkg::LDAC_TOP_FIXED: legal_top = s;
      default:                  legal_top = ldac_pkg::LDAC_TOP_SUPPLY;
    endcase
  endfunction

  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_we) begin
      ctrl_d = ctrl_wdata;
      ctrl_d.positive_source_sel = legal_top(ctrl_wdata.positive_source_sel);
    end
  end

  // Ladder switch decode; the analog ladder forms bottom + (top-bottom)*code/32
  always_comb begin
    ladder_d.top_sel   = ctrl_q.positive_source_sel;
    ladder_d.bot_sel   = ctrl_q.negative_source_sel;
    ladder_d.tap_sel   = ctrl_q.level_code;
    ladder_d.tap_drive = ctrl_q.conv_enable;
    if (ctrl_q.conv_enable) begin
      ladder_d.top_connect = 1'b1;
      ladder_d.bot_connect = 1'b1;
    end else begin
      // One ladder end stays tied so the output clamps to it
      ladder_d.top_connect = ctrl_q.low_power_source_sel;
      ladder_d.bot_connect = !ctrl_q.low_power_source_sel;
    end
    ladder_d.route_cmp = 1'b1;
    ladder_d.route_adc = 1'b1;
    ladder_d.route_pin = ctrl_q.pin_output_enable;
  end

  // Pad input synchroniser; stage 0 is read only by stage 1
  always_comb begin
    pad_sync_d = {pad_sync_q[1:0], pad_in};
    pad_in_d   = pad_in_q;
    if (pad_sync_q[1] == pad_sync_q[2]) begin
      pad_in_d = pad_sync_q[2];
    end
  end

  ldac_pin_mux u_pin_mux (
    .analog_sel  (ctrl_q.pin_output_enable),
    .port_out    (port_out),
    .port_tris   (port_tris),
    .pad_in      (pad_in_q),
    .pad_out     (mux_out),
    .pad_oe_n    (mux_oe_n),
    .pad_ibuf_en (mux_ibuf),
    .port_read   (mux_read)
  );

  // Control word register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= ldac_pkg::CTRL_RESET;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
    end
  end

  // Ladder switch register; all switches open in reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ladder_q <= '0;
    end else if (clk_en) begin
      ladder_q <= ladder_d;
    end
  end

  // Pad input synchroniser stages and accepted level
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pad_sync_q <= 3'h0;
      pad_in_q   <= 1'b0;
    end else if (clk_en) begin
      pad_sync_q <= pad_sync_d;
      pad_in_q   <= pad_in_d;
    end
  end

  // Pad controls; reset leaves the driver off and the input buffer on
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pad_out_q   <= 1'b0;
      pad_oe_n_q  <= 1'b1;
      pad_ibuf_q  <= 1'b1;
      port_read_q <= 1'b0;
    end else if (clk_en) begin
      pad_out_q   <= mux_out;
      pad_oe_n_q  <= mux_oe_n;
      pad_ibuf_q  <= mux_ibuf;
      port_read_q <= mux_read;
    end
  end

  assign ctrl_rdata  = ctrl_q;
  assign ladder      = ladder_q;
  assign pad_out     = pad_out_q;
  assign pad_oe_n    = pad_oe_n_q;
  assign pad_ibuf_en = pad_ibuf_q;
  assign port_read   = port_read_q;
endmodule
`default_nettype wire

// [verification/ldac_chk_sva.sv]
// Checker for the ladder converter control outputs
`timescale 1ns/1ns
`default_nettype none
module ldac_chk (
  // Clock and control
  input wire logic                   mclk,
  input wire logic                   rstn,
  input wire logic                   clk_en,
  input wire logic                   ctrl_we,
  input wire ldac_pkg::ldac_ctrl_t   ctrl_wdata,
  input wire ldac_pkg::ldac_ctrl_t   ctrl_rdata,
  // Outputs
  input wire ldac_pkg::ldac_ladder_t ladder,
  input wire logic                   pad_out,
  input wire logic                   pad_oe_n,
  input wire logic                   pad_ibuf_en,
  input wire logic                   port_read
);
  logic                 upd_q;
  ldac_pkg::ldac_ctrl_t p_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      upd_q <= 1'b0;
      p_q   <= '0;
    end else begin
      upd_q <= clk_en;
      p_q   <= ctrl_rdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_pin_on;
    upd_q && p_q.pin_output_enable;
  endsequence
  a_take_write: assert property (clk_en && ctrl_we |=>
    ctrl_rdata.level_code == $past(ctrl_wdata.level_code)) else $error("write lost");
  a_tap_code: assert property (upd_q |-> ladder.tap_sel == p_q.level_code)
    else $error("tap code");
  a_tap_drive: assert property (upd_q |-> ladder.tap_drive == p_q.conv_enable)
    else $error("tap drive");
  a_low_power: assert property (upd_q && !p_q.conv_enable |->
    ladder.top_connect == p_q.low_power_source_sel
    && ladder.bot_connect != p_q.low_power_source_sel) else $error("ladder ends");
  a_src_sel: assert property (upd_q |-> ladder.top_sel == p_q.positive_source_sel
    && ladder.bot_sel == p_q.negative_source_sel) else $error("sources");
  a_out_routes: assert property (upd_q |-> ladder.route_cmp && ladder.route_adc
    && ladder.route_pin == p_q.pin_output_enable) else $error("routes");
  a_pin_kill: assert property (s_pin_on |-> pad_oe_n && !pad_ibuf_en && !pad_out)
    else $error("pin buffers");
  a_read_zero: assert property (s_pin_on |-> !port_read)
    else $error("pin read");
endmodule
bind ladder_dac_control ldac_chk u_chk (.*);
`default_nettype wire

// [verification/ladder_dac_control_tb.sv]
// Self-checking bench for the ladder converter control
`timescale 1ns/1ns
`default_nettype none
module ladder_dac_control_tb;
  logic                   mclk, rstn, clk_en, ctrl_we, port_out, port_tris, pad_in;
  logic                   pad_out, pad_oe_n, pad_ibuf_en, port_read;
  ldac_pkg::ldac_ctrl_t   ctrl_wdata, ctrl_rdata;
  ldac_pkg::ldac_ladder_t ladder;
  int                     n_fail, checks;
  ladder_dac_control uut (.*);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  function automatic ldac_pkg::ldac_ctrl_t mk(input logic en, lp, oe, input logic [1:0] ps,
    input logic ns, input logic [4:0] lv);
    mk = {en, lp, oe, ps, ns, lv};
  endfunction
  // Write at a falling edge, return once ladder and pad have followed
  task automatic wr(input ldac_pkg::ldac_ctrl_t v);
    ctrl_we = 1'b1;
    ctrl_wdata = v;
    @(negedge mclk);
    ctrl_we = 1'b0;
    @(negedge mclk);
  endtask
  task automatic t_levels;
    for (int i = 0; i < 32; i++) begin
      wr(mk(1'b1, i[0], 1'b0, 2'(i % 3), i[1], 5'(i)));
      chk(ladder.tap_drive === 1'b1 && ladder.tap_sel === 5'(i), "level");
      chk(ladder.top_sel === 2'(i % 3) && ladder.bot_sel === i[1], "source");
    end
  endtask
  task automatic t_clamp;
    wr(mk(1'b0, 1'b1, 1'b0, 2'h2, 1'b0, ldac_pkg::LEVEL_ONES));
    chk(!ladder.tap_drive && ladder.top_connect && !ladder.bot_connect, "hi");
    wr(mk(1'b0, 1'b0, 1'b0, 2'h0, 1'b1, ldac_pkg::LEVEL_ZERO));
    chk(!ladder.top_connect && ladder.bot_connect, "lo");
    wr(mk(1'b1, 1'b0, 1'b0, 2'h3, 1'b0, 5'h01));
    chk(ctrl_rdata.positive_source_sel === ldac_pkg::LDAC_TOP_SUPPLY, "sel3");
    clk_en = 1'b0;
    wr(mk(1'b1, 1'b0, 1'b0, 2'h1, 1'b0, 5'h1e));
    chk(ctrl_rdata.level_code === 5'h01, "frozen");
    clk_en = 1'b1;
  endtask
  task automatic t_pin;
    port_out = 1'b1;
    port_tris = 1'b0;
    pad_in = 1'b1;
    wr(mk(1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 5'h10));
    repeat (6) @(negedge mclk);
    chk(pad_out === 1'b1 && pad_oe_n === 1'b0 && port_read === 1'b1, "digital");
    chk(pad_ibuf_en === 1'b1, "ibuf on");
    wr(mk(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 5'h10));
    chk(ladder.route_pin && ladder.route_cmp && ladder.route_adc, "route");
    chk(pad_oe_n === 1'b1 && pad_ibuf_en === 1'b0 && pad_out === 1'b0, "pad");
    chk(port_read === 1'b0, "read");
  endtask
  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {rstn, ctrl_we, ctrl_wdata, port_out, pad_in} = '0;
    {clk_en, port_tris} = 2'h3;
    repeat (20) @(negedge mclk);
    chk(ctrl_rdata === ldac_pkg::CTRL_RESET && ladder === '0 && pad_oe_n, "reset");
    rstn = 1'b1;
    @(negedge mclk);
    t_levels();
    t_clamp();
    t_pin();
    results();
  end
  initial begin
    #20000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
